// ### cfg_root_model.sv
// Root-side model issuing configuration reads and writes to the register bank
`timescale 1ns/100ps
module cfg_root_model
   import pcie_status_pkg::*;
(
   input  wire logic                       sys_clk,
   output logic                            cfg_rd,
   output logic                            cfg_wr,
   output pcie_status_pkg::cfg_addr_t      cfg_addr,
   output pcie_status_pkg::cfg_be_t        cfg_be,
   output pcie_status_pkg::dword_t         cfg_wdata,
   input  wire pcie_status_pkg::dword_t    cfg_rdata,
   input  wire logic                       cfg_rvalid,
   output logic                            common_clock_config
);
   import pcie_status_pkg::*;

   // ****************************************************************
   // Idle levels at time zero
   // ****************************************************************
   initial begin
      cfg_rd              = 1'b0;
      cfg_wr              = 1'b0;
      cfg_addr            = 8'h00;
      cfg_be              = 4'h0;
      cfg_wdata           = 32'h0000_0000;
      common_clock_config = 1'b0;
   end

   // Called just after a falling edge; holds for one rising edge, then idles one
   task automatic cfg_write(input cfg_addr_t a, input cfg_be_t be, input dword_t d);
      cfg_wr    = 1'b1;
      cfg_addr  = a;
      cfg_be    = be;
      cfg_wdata = d;
      @(negedge sys_clk);
      cfg_wr    = 1'b0;
      // Released lines flip so a stale value is never mistaken for live
      cfg_addr  = ~a;
      cfg_be    = ~be;
      cfg_wdata = ~d;
      // Idle edge keeps the next request apart from this release
      @(negedge sys_clk);
   endtask

   // Answer is registered, so it is settled by the next falling edge
   task automatic cfg_read(input cfg_addr_t a, output dword_t d, output logic v);
      cfg_rd   = 1'b1;
      cfg_addr = a;
      @(negedge sys_clk);
      cfg_rd   = 1'b0;
      cfg_addr = ~a;
      d        = cfg_rdata;
      v        = cfg_rvalid;
      @(negedge sys_clk);
   endtask

   // Software choice of shared or asynchronous reference clock
   task automatic set_common_clock(input logic c);
      common_clock_config = c;
   endtask
endmodule

// ### err_flag_if.sv
// Set, clear and state lines of the write-one-to-clear error flags
`timescale 1ns/100ps
interface err_flag_if;
   import pcie_status_pkg::*;

   logic [NUM_ERR_FLAGS-1:0] set_evt;
   logic [NUM_ERR_FLAGS-1:0] clr;
   logic [NUM_ERR_FLAGS-1:0] flags;

   modport owner (input set_evt, input clr, output flags);
   modport user  (output set_evt, output clr, input flags);
endinterface

// ### error_flag_bank.sv
// Sticky error flags with write-one-to-clear and set-over-clear priority
`timescale 1ns/100ps
module error_flag_bank
   import pcie_status_pkg::*;
(
   input  wire logic      sys_clk,
   input  wire logic      rst_n,
   input  wire logic      clk_en,
   err_flag_if.owner      fl
);

   typedef struct packed {
      logic [NUM_ERR_FLAGS-1:0] flags;
   } flag_state_t;

   flag_state_t              st_q;
   flag_state_t              st_d;
   logic [NUM_ERR_FLAGS-1:0] nxt;

   // ****************************************************************
   // Per-flag next value
   // ****************************************************************
   // Set term ORed last so an event in the clearing cycle survives
   for (genvar k = 0; k < NUM_ERR_FLAGS; k++) begin : g_flag
      assign nxt[k] = fl.set_evt[k] | (st_q.flags[k] & ~fl.clr[k]);
   end

   // Frozen while the clock enable is low
   always_comb begin
      st_d = st_q;
      if (clk_en) begin
         st_d.flags = nxt;
      end
   end

   // State register, cleared on reset
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign fl.flags = st_q.flags;

endmodule

// ### pcie_status_link_caps.sv
// Device status and link capability registers behind the configuration access port
`timescale 1ns/100ps
module pcie_status_link_caps
   import pcie_status_pkg::*;
#(
   parameter logic [5:0] MAX_LINK_WIDTH = LINK_WIDTH_X8
)
(
   input  wire logic                       sys_clk,
   input  wire logic                       rst_n,
   input  wire logic                       clk_en,
   input  wire logic                       cfg_rd,
   input  wire logic                       cfg_wr,
   input  wire pcie_status_pkg::cfg_addr_t cfg_addr,
   input  wire pcie_status_pkg::cfg_be_t   cfg_be,
   input  wire pcie_status_pkg::dword_t    cfg_wdata,
   output      pcie_status_pkg::dword_t    cfg_rdata,
   output      logic                       cfg_rvalid,
   input  wire logic                       func_parity_err,
   input  wire logic                       link_ur_err,
   input  wire logic                       link_fatal_err,
   input  wire logic                       link_nonfatal_err,
   input  wire logic                       link_corr_err,
   input  wire logic                       common_clock_config,
   input  wire logic                       non_fatal_report_enable,
   input  wire logic                       unsupported_request_report_enable,
   output      logic                       nonfatal_msg,
   output      logic                       ur_msg
);

   import pcie_status_pkg::*;

   // ****************************************************************
   // Elaboration checks
   // ****************************************************************
   // Width codes above x32 are not defined for the link
   if (MAX_LINK_WIDTH == 6'h00 || MAX_LINK_WIDTH > 6'h20) begin : g_bad_width
      $error("MAX_LINK_WIDTH must lie between 1 and 32");
   end

   // ****************************************************************
   // Address decode
   // ****************************************************************
   // Status sits in the upper half of its dword, so reads and clears shift
   localparam cfg_addr_t STATUS_DWORD = {DEV_STATUS_OFS[7:2], 2'b00};
   localparam cfg_addr_t CAPS_DWORD   = {LINK_CAPS_OFS[7:2], 2'b00};
   localparam int        STATUS_SHIFT = 8 * int'(DEV_STATUS_OFS[1:0]);
   localparam int        STATUS_LANE  = int'(DEV_STATUS_OFS[1:0]);

   typedef struct packed {
      dword_t rdata;
      logic   rvalid;
      logic   nf_msg;
      logic   ur_msg;
   } top_state_t;

   top_state_t  st_q;
   top_state_t  st_d;
   cfg_addr_t   dw_addr;
   logic        hit_status;
   logic        hit_caps;
   logic [2:0]  l0s_exit;
   dword_t      caps_val;
   logic [15:0] status_val;

   err_flag_if fl ();

   // Low address bits only pick byte lanes, so compare whole dwords
   assign dw_addr    = {cfg_addr[7:2], 2'b00};
   assign hit_status = (dw_addr == STATUS_DWORD);
   assign hit_caps   = (dw_addr == CAPS_DWORD);

   // ****************************************************************
   // Error flag sources and clears
   // ****************************************************************
   // A parity-bad write counts as both unsupported and non-fatal
   assign fl.set_evt[UR_DET_BIT]    = func_parity_err | link_ur_err;
   assign fl.set_evt[FATAL_DET_BIT] = link_fatal_err;
   assign fl.set_evt[NF_DET_BIT]    = func_parity_err | link_nonfatal_err;
   assign fl.set_evt[CORR_DET_BIT]  = link_corr_err;

   // Only the lane that holds the flags can clear them
   assign fl.clr = (cfg_wr && hit_status && cfg_be[STATUS_LANE])
                   ? cfg_wdata[STATUS_SHIFT +: NUM_ERR_FLAGS] : '0;

   error_flag_bank u_flags (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .clk_en  (clk_en),
      .fl      (fl)
   );

   // ****************************************************************
   // Register images
   // ****************************************************************
   // Exit latency tracks the common-clock bit as software changes it
   assign l0s_exit = common_clock_config ? L0S_EXIT_COMMON : L0S_EXIT_ASYNC;

   // Status: pending and aux power fixed low, no non-posted traffic
   always_comb begin
      status_val = DEV_STATUS_RESET;
      status_val[NUM_ERR_FLAGS-1:0] = fl.flags;
      status_val[PENDING_BIT] = 1'b0;
      status_val[AUX_PWR_BIT] = 1'b0;
   end

   // Capabilities assembled from fixed fields plus the live latency
   // Nothing here is writable, so no storage is spent on this register
   always_comb begin
      caps_val = '0;
      caps_val[PORT_NUM_LSB +: 8]   = PORT_NUM_VAL;
      caps_val[L1_EXIT_LSB +: 3]    = L1_EXIT_NOT_SUPP;
      caps_val[L0S_EXIT_LSB +: 3]   = l0s_exit;
      caps_val[ASPM_LSB +: 2]       = ASPM_RESET;
      caps_val[LINK_WIDTH_LSB +: 6] = MAX_LINK_WIDTH;
      caps_val[LINK_SPEED_LSB +: 4] = LINK_SPEED_2G5;
   end

   // ****************************************************************
   // Read path and error messages
   // ****************************************************************
   // Unmapped reads answer zero so the root never waits forever
   always_comb begin
      st_d = st_q;
      if (clk_en) begin
         st_d.rvalid = cfg_rd;
         st_d.rdata  = '0;
         // Data is zero outside a read so a stale word never lingers
         if (cfg_rd && hit_status) begin
            st_d.rdata[STATUS_SHIFT +: 16] = status_val;
         end else if (cfg_rd && hit_caps) begin
            st_d.rdata = caps_val;
         end
         // Messages only for the function's own parity errors
         st_d.nf_msg = func_parity_err & non_fatal_report_enable;
         st_d.ur_msg = func_parity_err & unsupported_request_report_enable;
      end
   end

   // Output and state register
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign cfg_rdata    = st_q.rdata;
   assign cfg_rvalid   = st_q.rvalid;
   assign nonfatal_msg = st_q.nf_msg;
   assign ur_msg       = st_q.ur_msg;

   // ****************************************************************
   // Assertions
   // ****************************************************************
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_n);

   // Write that clears flags with no event on the same edge
   sequence s_clear_write;
      clk_en && cfg_wr && hit_status && cfg_be[STATUS_LANE] && (fl.set_evt == '0);
   endsequence

   // Read of status dword taken on an enabled edge
   sequence s_read_status;
      clk_en && cfg_rd && hit_status;
   endsequence

   // Read of capability dword taken on an enabled edge
   sequence s_read_caps;
      clk_en && cfg_rd && hit_caps;
   endsequence

   // Read of any other dword, answered with zero
   sequence s_read_other;
      clk_en && cfg_rd && !hit_status && !hit_caps;
   endsequence

   AST_UR_PARITY: assert property (
      clk_en && func_parity_err |=> fl.flags[UR_DET_BIT])
      else $error("Parity-bad write did not set unsupported flag");

   AST_UR_LINK: assert property (
      clk_en && link_ur_err |=> fl.flags[UR_DET_BIT])
      else $error("Link unsupported error did not set flag");

   AST_UR_SOURCE: assert property (
      $rose(fl.flags[UR_DET_BIT]) |-> $past((func_parity_err || link_ur_err) && clk_en))
      else $error("Unsupported flag rose without a source event");

   AST_FATAL_SOURCE: assert property (
      $rose(fl.flags[FATAL_DET_BIT]) |-> $past(link_fatal_err && clk_en))
      else $error("Fatal flag rose without a link fatal error");

   AST_NF_PARITY: assert property (
      clk_en && func_parity_err |=> fl.flags[NF_DET_BIT])
      else $error("Parity-bad write did not set non-fatal flag");

   AST_NF_LINK: assert property (
      clk_en && link_nonfatal_err |=> fl.flags[NF_DET_BIT])
      else $error("Link uncorrectable error did not set non-fatal flag");

   AST_NF_SOURCE: assert property (
      $rose(fl.flags[NF_DET_BIT]) |-> $past((func_parity_err || link_nonfatal_err) && clk_en))
      else $error("Non-fatal flag rose without a source event");

   AST_CORR_SOURCE: assert property (
      $rose(fl.flags[CORR_DET_BIT]) |-> $past(link_corr_err && clk_en))
      else $error("Correctable flag rose without a link correctable error");

   AST_W1C: assert property (
      s_clear_write |=> (fl.flags & $past(cfg_wdata[STATUS_SHIFT +: NUM_ERR_FLAGS])) == '0)
      else $error("Write of one did not clear status flag");

   AST_FLAG_HOLD: assert property (
      !clk_en |=> $stable(fl.flags))
      else $error("Flags moved while clock enable was low");

   // Writes elsewhere, or with the flag lane off, must leave the flags alone
   AST_CLEAR_LANE: assert property (
      clk_en && cfg_wr && !(hit_status && cfg_be[STATUS_LANE]) |-> fl.clr == '0)
      else $error("Clear strobe from a write outside the flag lane");

   // Per-flag checks: an event on an enabled edge always lands, and only a write of one clears
   for (genvar k = 0; k < NUM_ERR_FLAGS; k++) begin : g_flag_chk
      AST_SET_LANDS: assert property (
         clk_en && fl.set_evt[k] |=> fl.flags[k])
         else $error("Flag event was lost");

      AST_CLEAR_SOURCE: assert property (
         $fell(fl.flags[k]) |-> $past(fl.clr[k] && clk_en))
         else $error("Flag cleared without a write of one");
   end

   AST_RD_STATUS: assert property (
      s_read_status |=> cfg_rvalid && cfg_rdata[31:20] == 12'h000
                      && cfg_rdata[19:16] == $past(fl.flags))
      else $error("Status read returned wrong image");

   // Lower half of the status dword belongs to another register
   AST_STATUS_LOW: assert property (
      s_read_status |=> cfg_rdata[15:0] == 16'h0000)
      else $error("Status read returned data in lower half");

   AST_STATUS_RO_BITS: assert property (
      status_val[15:NUM_ERR_FLAGS] == '0)
      else $error("Read-only status bits not zero");

   AST_CAPS_FIXED: assert property (
      s_read_caps |=> cfg_rvalid && cfg_rdata[31:15] == 17'h00007
                      && cfg_rdata[11:0] == {ASPM_RESET, MAX_LINK_WIDTH, LINK_SPEED_2G5})
      else $error("Link capability fixed fields wrong");

   AST_CAPS_L0S: assert property (
      s_read_caps |=> cfg_rdata[14:12] ==
                      ($past(common_clock_config) ? L0S_EXIT_COMMON : L0S_EXIT_ASYNC))
      else $error("L0s exit latency does not follow common clock bit");

   AST_UNMAPPED_ZERO: assert property (
      s_read_other |=> cfg_rvalid && cfg_rdata == '0)
      else $error("Unmapped read did not answer zero");

   AST_SET_WINS: assert property (
      clk_en && fl.set_evt[UR_DET_BIT] && fl.clr[UR_DET_BIT] |=> fl.flags[UR_DET_BIT] [*1] ##1 1)
      else $error("Same-cycle clear lost an unsupported event");

   AST_MSG_NF: assert property (
      clk_en && func_parity_err |=> nonfatal_msg == $past(non_fatal_report_enable))
      else $error("Non-fatal message not gated by its enable");

   AST_MSG_UR: assert property (
      clk_en && !func_parity_err |=> !ur_msg && !nonfatal_msg)
      else $error("Error message without a parity error");

   AST_MSG_UR_GATE: assert property (
      clk_en && func_parity_err |=> ur_msg == $past(unsupported_request_report_enable))
      else $error("Unsupported message not gated by its enable");

   AST_RVALID_PULSE: assert property (
      clk_en && !cfg_rd |=> !cfg_rvalid)
      else $error("Read answer without a read");

   AST_RVALID_ON_READ: assert property (
      clk_en && cfg_rd |=> cfg_rvalid)
      else $error("Read taken without an answer");

   // Frozen edges must hold every output as it stands
   AST_OUT_HOLD: assert property (
      !clk_en |=> $stable(cfg_rdata) && $stable(cfg_rvalid)
                  && $stable(ur_msg) && $stable(nonfatal_msg))
      else $error("Outputs moved while clock enable was low");

endmodule

// ### pcie_status_link_caps_bench.sv
// Self-checking bench for the device status and link capability registers
`timescale 1ns/100ps
module pcie_status_link_caps_bench;
   import pcie_status_pkg::*;

   logic sys_clk;
   logic rst_n;
   logic clk_en;
   logic [4:0] evt;
   logic nf_en;
   logic ur_en;
   logic cfg_rd;
   logic cfg_wr;
   logic common_clock_config;
   logic cfg_rvalid;
   logic nonfatal_msg;
   logic ur_msg;
   cfg_addr_t cfg_addr;
   cfg_be_t   cfg_be;
   dword_t    cfg_wdata;
   dword_t    cfg_rdata;
   int errors;
   int checks_done;
   int cycles;
   logic [3:0] exp_flags [5] = '{4'ha, 4'h8, 4'h4, 4'h2, 4'h1};

   cfg_root_model root (.sys_clk(sys_clk), .cfg_rd(cfg_rd), .cfg_wr(cfg_wr),
      .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
      .cfg_rvalid(cfg_rvalid), .common_clock_config(common_clock_config));

   pcie_status_link_caps dut (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en),
      .cfg_rd(cfg_rd), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr), .cfg_be(cfg_be),
      .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid),
      .func_parity_err(evt[0]), .link_ur_err(evt[1]), .link_fatal_err(evt[2]),
      .link_nonfatal_err(evt[3]), .link_corr_err(evt[4]),
      .common_clock_config(common_clock_config), .non_fatal_report_enable(nf_en),
      .unsupported_request_report_enable(ur_en), .nonfatal_msg(nonfatal_msg),
      .ur_msg(ur_msg));

   // ****************************************************************
   // Clock, hang guard and reporting
   // ****************************************************************
   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end

   // Whole run is about 115 cycles; the ceiling leaves wide margin
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 5000) begin
         errors++;
         report_and_stop();
      end
   end

   task automatic check(input string name, input dword_t seen, input dword_t exp);
      checks_done++;
      if (seen !== exp) begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic rd_chk(input string name, input cfg_addr_t a, input dword_t exp);
      dword_t d;
      logic   v;
      root.cfg_read(a, d, v);
      check({name, " valid"}, {31'h0, v}, 32'h1);
      check(name, d, exp);
   endtask

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // ****************************************************************
   // Test sequence
   // ****************************************************************
   initial begin
      rst_n = 1'b0;
      clk_en = 1'b1;
      evt = 5'h00;
      nf_en = 1'b0;
      ur_en = 1'b0;
      repeat (10) @(negedge sys_clk);
      rst_n = 1'b1;
      rd_chk("status reset", DEV_STATUS_OFS, 32'h0000_0000);
      rd_chk("caps reset", LINK_CAPS_OFS, 32'h0003_e081);
      rd_chk("unmapped", 8'h60, 32'h0000_0000);
      $display("test done: reset values");
      // L0s latency tracks the clocking choice both ways
      for (int c = 1; c >= 0; c--) begin
         root.set_common_clock(c[0]);
         rd_chk("caps common clock", LINK_CAPS_OFS, c ? 32'h0003_a081 : 32'h0003_e081);
      end
      $display("test done: l0s latency");
      // Each source alone under each enable; only the parity error sends a message
      for (int p = 0; p < 2; p++) begin
         nf_en = (p == 0);
         ur_en = (p == 1);
         for (int i = 0; i < 5; i++) begin
            evt = 5'(1 << i);
            @(negedge sys_clk);
            evt = 5'h00;
            check("messages", {30'h0, nonfatal_msg, ur_msg},
                  {30'h0, (i == 0) && nf_en, (i == 0) && ur_en});
            rd_chk("flags", DEV_STATUS_OFS, {12'h0, exp_flags[i], 16'h0});
            root.cfg_write(DEV_STATUS_OFS, 4'b0100, 32'h000f_0000);
            rd_chk("cleared", DEV_STATUS_OFS, 32'h0000_0000);
         end
      end
      $display("test done: error sources");
      // Event landing on the same edge as its clear must survive
      evt = 5'h10;
      fork
         root.cfg_write(DEV_STATUS_OFS, 4'b0100, 32'h000f_0000);
         @(negedge sys_clk) evt = 5'h00;
      join
      rd_chk("set beats clear", DEV_STATUS_OFS, 32'h0001_0000);
      // Partial clear; ones written to read-only bits change nothing
      evt = 5'h1f;
      @(negedge sys_clk);
      evt = 5'h00;
      root.cfg_write(DEV_STATUS_OFS, 4'b1111, 32'hfff5_ffff);
      rd_chk("partial clear", DEV_STATUS_OFS, 32'h000a_0000);
      root.cfg_write(DEV_STATUS_OFS, 4'b1011, 32'h000f_0000);
      rd_chk("lane off", DEV_STATUS_OFS, 32'h000a_0000);
      root.cfg_write(LINK_CAPS_OFS, 4'b1111, 32'hffff_ffff);
      rd_chk("caps read only", LINK_CAPS_OFS, 32'h0003_e081);
      $display("test done: clear behaviour");
      // Frozen clock enable drops an event
      clk_en = 1'b0;
      evt = 5'h04;
      @(negedge sys_clk);
      evt = 5'h00;
      clk_en = 1'b1;
      rd_chk("frozen", DEV_STATUS_OFS, 32'h000a_0000);
      $display("test done: clock enable");
      // Reset in mid-run clears flags and outputs at once
      evt = 5'h1f;
      @(negedge sys_clk);
      evt = 5'h00;
      rst_n = 1'b0;
      repeat (2) @(negedge sys_clk);
      check("outputs in reset", {29'h0, cfg_rvalid, nonfatal_msg, ur_msg}, 32'h0);
      check("rdata in reset", cfg_rdata, 32'h0);
      rst_n = 1'b1;
      rd_chk("status after reset", DEV_STATUS_OFS, 32'h0000_0000);
      $display("test done: mid-run reset");
      report_and_stop();
   end
endmodule

// ### pcie_status_pkg.sv
// Shared offsets, field layouts and reset values for the status and link capability bank
package pcie_status_pkg;

   // ****************************************************************
   // Access port types
   // ****************************************************************
   typedef logic [7:0]  cfg_addr_t;
   typedef logic [3:0]  cfg_be_t;
   typedef logic [31:0] dword_t;

   // ****************************************************************
   // Register offsets and reset values
   // ****************************************************************
   localparam cfg_addr_t DEV_STATUS_OFS  = 8'h4e;
   localparam cfg_addr_t LINK_CAPS_OFS   = 8'h50;
   localparam logic [15:0] DEV_STATUS_RESET = 16'h0000;
   localparam dword_t    LINK_CAPS_RESET = 32'h0003e081;

   // ****************************************************************
   // Device status field positions
   // ****************************************************************
   localparam int NUM_ERR_FLAGS  = 4;
   localparam int UR_DET_BIT     = 3;
   localparam int FATAL_DET_BIT  = 2;
   localparam int NF_DET_BIT     = 1;
   localparam int CORR_DET_BIT   = 0;
   localparam int PENDING_BIT    = 5;
   localparam int AUX_PWR_BIT    = 4;

   // ****************************************************************
   // Link capability field positions and values
   // ****************************************************************
   localparam int PORT_NUM_LSB   = 24;
   localparam int L1_EXIT_LSB    = 15;
   localparam int L0S_EXIT_LSB   = 12;
   localparam int ASPM_LSB       = 10;
   localparam int LINK_WIDTH_LSB = 4;
   localparam int LINK_SPEED_LSB = 0;
   localparam logic [7:0] PORT_NUM_VAL     = 8'h00;
   localparam logic [2:0] L1_EXIT_NOT_SUPP = 3'h7;
   localparam logic [2:0] L0S_EXIT_ASYNC   = 3'h6;
   localparam logic [2:0] L0S_EXIT_COMMON  = 3'h2;
   localparam logic [1:0] ASPM_RESET       = 2'h0;
   localparam logic [5:0] LINK_WIDTH_X8    = 6'h08;
   localparam logic [3:0] LINK_SPEED_2G5   = 4'h1;

endpackage
